// File: verilog/iamp_top.sv
// Purpose: serial bus address recognition and register pointer
// Assumes: link_clk oversamples scl and sda many times per bit
// Notes: register accesses leave on the mclk side as strobes
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module iamp_top
  import iamp_pkg::*;
(
  input logic mclk,
  input logic rst_n,
  input logic link_clk,
  input logic scl_i,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input logic [6:0] strap_pin,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  output logic soft_reset_call
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CTRL, ST_WDATA, ST_ACK_WAIT, ST_ACK, ST_RDATA, ST_MACK
  } iamp_state_t;

  logic lrst_meta_r;
  logic link_rst_n;
  logic [8:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic [6:0] strap_s;
  logic scl_prev_r;
  logic sda_prev_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  iamp_state_t state_r;
  iamp_state_t after_ack_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic sda_oe_r;
  logic sda_o_r;
  logic [7:0] rx_byte;
  logic byte_done;
  logic addr_done;
  logic ctrl_done;
  logic wdata_done;
  logic ind_hit;
  logic grp_hit;
  logic sub_hit;
  logic soft_hit;
  logic addr_hit;
  logic ctrl_ok;
  logic read_issue;
  logic pointer_increment_flag_r;
  logic [5:0] ptr_r;
  logic [5:0] ptr_nxt;
  logic increment_range_bit_hi_r;
  logic increment_range_bit_lo_r;
  logic group_en_r;
  logic sub_one_en_r;
  logic sub_two_en_r;
  logic sub_three_en_r;
  logic [6:0] group_call_address_r;
  logic [6:0] sub_call_address_one_r;
  logic [6:0] sub_call_address_two_r;
  logic [6:0] sub_call_address_three_r;
  logic ev_valid;
  logic [1:0] ev_kind;
  logic ev_valid_m;
  logic [EV_W-1:0] ev_data_m;
  logic rd_valid_l;
  logic [7:0] rd_data_l;
  logic [7:0] rd_byte_r;
  logic reg_wr_r;
  logic reg_rd_r;
  logic rd_cap_r;
  logic [5:0] reg_addr_r;
  logic [7:0] reg_wdata_r;
  logic soft_r;

  // next pointer; with the increment flag set, a pointer at the top of the map rolls to zero in every range mode
  function automatic logic [5:0] iamp_next_ptr(input logic flag, input logic hi, input logic lo,
                                               input logic [5:0] p);
    logic [5:0] n;
    n = 6'(p + 6'h01);
    if (!flag) begin
      n = p;
    end else if (p == PTR_LAST) begin
      n = PTR_FIRST;
    end else begin
      case ({hi, lo})
        2'h1: if (p == PTR_BRIGHT_LAST) n = PTR_BRIGHT_FIRST;
        2'h2: if (p == PTR_CHASE) n = PTR_GLOBAL_FIRST;
        2'h3: if (p == PTR_CHASE) n = PTR_BRIGHT_FIRST;
        default: n = n;
      endcase
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link clock domain: reset release, pins, bus conditions

  // reset release is synchronised so the link logic leaves reset cleanly
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_meta_r <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      lrst_meta_r <= 1'b1;
      link_rst_n <= lrst_meta_r;
    end
  end

  // bus pins pass inverted so the zero reset of the synchroniser reads as an idle high bus
  iamp_sync #(.W(9)) u_pins (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({strap_pin, ~scl_i, ~sda_i}),
    .q(pin_s)
  );
  assign strap_s = pin_s[8:2];
  assign scl_s = ~pin_s[1];
  assign sda_s = ~pin_s[0];

  // previous levels reset high so reset release looks like an idle bus
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_r;
  assign scl_fall = ~scl_s & scl_prev_r;
  assign start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  assign stop_det = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // byte decode and address matching

  assign rx_byte = {rx_r[6:0], sda_s};
  assign byte_done = scl_rise && (bit_cnt_r == BIT_LAST);
  assign addr_done = byte_done && (state_r == ST_ADDR);
  assign ctrl_done = byte_done && (state_r == ST_CTRL);
  assign wdata_done = byte_done && (state_r == ST_WDATA);

  // straps compared bit for bit with no filtering of reserved values
  assign ind_hit = (rx_byte[7:1] == strap_s);
  assign grp_hit = group_en_r && (rx_byte[7:1] == group_call_address_r);
  assign sub_hit = (sub_one_en_r && (rx_byte[7:1] == sub_call_address_one_r)) ||
                   (sub_two_en_r && (rx_byte[7:1] == sub_call_address_two_r)) ||
                   (sub_three_en_r && (rx_byte[7:1] == sub_call_address_three_r));
  // full byte compare: the read form of this call falls through unanswered
  assign soft_hit = (rx_byte == SOFT_RESET_BYTE) && !ind_hit && !grp_hit && !sub_hit;
  assign addr_hit = ind_hit || grp_hit || sub_hit || soft_hit;
  assign ctrl_ok = (rx_byte[CTRL_PTR_MSB:0] <= PTR_LAST);

  // a read byte is fetched as soon as it is known to be wanted
  assign read_issue = (addr_done && addr_hit && !soft_hit && rx_byte[0]) ||
                      ((state_r == ST_MACK) && scl_rise && !sda_s);

  ////////////////////////////////////////////////////////////////////////
  // serial state machine

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 3'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_CTRL, ST_WDATA: begin
          if (scl_rise) begin
            rx_r <= rx_byte;
            bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
          end
          if (addr_done) begin
            state_r <= addr_hit ? ST_ACK_WAIT : ST_IDLE;
            if (soft_hit) begin
              after_ack_r <= ST_IDLE;
            end else begin
              after_ack_r <= rx_byte[0] ? ST_RDATA : ST_CTRL;
            end
          end
          if (ctrl_done) begin
            state_r <= ctrl_ok ? ST_ACK_WAIT : ST_IDLE;
            after_ack_r <= ST_WDATA;
          end
          if (wdata_done) begin
            state_r <= ST_ACK_WAIT;
            after_ack_r <= ST_WDATA;
          end
        end
        ST_ACK_WAIT: begin
          // pull sda low only once scl is low, never while it is high
          if (scl_fall) begin
            sda_oe_r <= 1'b1;
            state_r <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 3'h0;
            state_r <= after_ack_r;
            tx_r <= rd_byte_r;
            sda_oe_r <= (after_ack_r == ST_RDATA) ? ~rd_byte_r[7] : 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == BIT_LAST) begin
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 3'h0;
              state_r <= ST_MACK;
            end else begin
              bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
        end
        ST_MACK: begin
          // master acknowledge: next byte goes out on the following fall
          if (scl_rise) begin
            state_r <= sda_s ? ST_IDLE : ST_ACK;
            after_ack_r <= ST_RDATA;
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // open drain: data is always low, the enable does the signalling
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_o_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control byte and pointer

  assign ptr_nxt = iamp_next_ptr(pointer_increment_flag_r, increment_range_bit_hi_r,
                                 increment_range_bit_lo_r, ptr_r);

  // bit six of the control byte is dropped on the floor
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pointer_increment_flag_r <= FLAG_RST;
      ptr_r <= PTR_FIRST;
    end else if (ctrl_done && ctrl_ok) begin
      pointer_increment_flag_r <= rx_byte[CTRL_FLAG_BIT];
      ptr_r <= rx_byte[CTRL_PTR_MSB:0];
    end else if (wdata_done || read_issue) begin
      ptr_r <= ptr_nxt;
    end
  end

  // snoop writes that land on the address and mode registers
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      increment_range_bit_hi_r <= RANGE_RST;
      increment_range_bit_lo_r <= RANGE_RST;
      group_en_r <= GROUP_EN_RST;
      sub_one_en_r <= SUB_EN_RST;
      sub_two_en_r <= SUB_EN_RST;
      sub_three_en_r <= SUB_EN_RST;
      group_call_address_r <= GROUP_ADDR_RST;
      sub_call_address_one_r <= SUB_ONE_RST;
      sub_call_address_two_r <= SUB_TWO_RST;
      sub_call_address_three_r <= SUB_THREE_RST;
    end else if (wdata_done) begin
      case (ptr_r)
        PTR_MODE: begin
          increment_range_bit_hi_r <= rx_byte[MODE_RANGE_HI];
          increment_range_bit_lo_r <= rx_byte[MODE_RANGE_LO];
          sub_one_en_r <= rx_byte[MODE_SUB_ONE];
          sub_two_en_r <= rx_byte[MODE_SUB_TWO];
          sub_three_en_r <= rx_byte[MODE_SUB_THREE];
          group_en_r <= rx_byte[MODE_GROUP];
        end
        PTR_SUB_ONE: sub_call_address_one_r <= rx_byte[7:1];
        PTR_SUB_TWO: sub_call_address_two_r <= rx_byte[7:1];
        PTR_SUB_THREE: sub_call_address_three_r <= rx_byte[7:1];
        PTR_GROUP: group_call_address_r <= rx_byte[7:1];
        default: group_en_r <= group_en_r;
      endcase
    end
  end

  // read data returned from the core clock side
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_byte_r <= 8'h00;
    end else if (rd_valid_l) begin
      rd_byte_r <= rd_data_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossings; bytes are microseconds apart so busy never blocks

  assign ev_valid = wdata_done || read_issue || (addr_done && soft_hit);
  assign ev_kind = wdata_done ? EV_WRITE : (read_issue ? EV_READ : EV_SOFT);

  iamp_xfer #(.W(EV_W)) u_ev (
    .src_clk(link_clk),
    .src_rst_n(link_rst_n),
    .src_valid(ev_valid),
    .src_data({ev_kind, ptr_r, rx_byte}),
    .src_busy(),
    .dst_clk(mclk),
    .dst_rst_n(rst_n),
    .dst_valid(ev_valid_m),
    .dst_data(ev_data_m)
  );

  iamp_xfer #(.W(8)) u_rd (
    .src_clk(mclk),
    .src_rst_n(rst_n),
    .src_valid(rd_cap_r),
    .src_data(reg_rdata),
    .src_busy(),
    .dst_clk(link_clk),
    .dst_rst_n(link_rst_n),
    .dst_valid(rd_valid_l),
    .dst_data(rd_data_l)
  );

  ////////////////////////////////////////////////////////////////////////
  // core clock domain: register strobes

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      soft_r <= 1'b0;
      rd_cap_r <= 1'b0;
      reg_addr_r <= PTR_FIRST;
      reg_wdata_r <= 8'h00;
    end else begin
      reg_wr_r <= ev_valid_m && (ev_data_m[15:14] == EV_WRITE);
      reg_rd_r <= ev_valid_m && (ev_data_m[15:14] == EV_READ);
      soft_r <= ev_valid_m && (ev_data_m[15:14] == EV_SOFT);
      // read data is taken one cycle after the strobe
      rd_cap_r <= reg_rd_r;
      if (ev_valid_m && (ev_data_m[15:14] != EV_SOFT)) begin
        reg_addr_r <= ev_data_m[13:8];
        reg_wdata_r <= ev_data_m[7:0];
      end
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe = sda_oe_r;
  assign reg_wr = reg_wr_r;
  assign reg_rd = reg_rd_r;
  assign reg_addr = reg_addr_r;
  assign reg_wdata = reg_wdata_r;
  assign soft_reset_call = soft_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_ack_fall;
    (state_r == ST_ACK_WAIT) && scl_fall;
  endsequence
  sequence s_ack_held;
    sda_oe_r && (state_r == ST_ACK);
  endsequence
  property p_ack_drive;
    @(posedge link_clk) disable iff (!link_rst_n) s_ack_fall |=> s_ack_held;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");
  property p_dir;
    @(posedge link_clk) disable iff (!link_rst_n)
      addr_done && addr_hit && !soft_hit |=> after_ack_r == (rx_r[0] ? ST_RDATA : ST_CTRL);
  endproperty
  a_dir: assert property (p_dir) else $error("direction misread");
  property p_strap;
    @(posedge link_clk) disable iff (!link_rst_n) addr_done && ind_hit |=> state_r == ST_ACK_WAIT;
  endproperty
  a_strap: assert property (p_strap) else $error("own address not acked");
  property p_group;
    @(posedge link_clk) disable iff (!link_rst_n) addr_done && grp_hit |=> state_r == ST_ACK_WAIT;
  endproperty
  a_group: assert property (p_group) else $error("group address not acked");
  property p_miss;
    @(posedge link_clk) disable iff (!link_rst_n) addr_done && !addr_hit |=> state_r == ST_IDLE ##1 !sda_oe_r;
  endproperty
  a_miss: assert property (p_miss) else $error("foreign address acked");
  property p_soft_read;
    @(posedge link_clk) disable iff (!link_rst_n)
      addr_done && (rx_byte == (SOFT_RESET_BYTE | 8'h01)) && !ind_hit && !grp_hit && !sub_hit
      |=> state_r == ST_IDLE;
  endproperty
  a_soft_read: assert property (p_soft_read) else $error("soft reset read acked");
  property p_ctrl_load;
    @(posedge link_clk) disable iff (!link_rst_n)
      ctrl_done && ctrl_ok |=> ptr_r == rx_r[5:0] && pointer_increment_flag_r == rx_r[7];
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("control byte not loaded");
  property p_ctrl_bad;
    @(posedge link_clk) disable iff (!link_rst_n) ctrl_done && !ctrl_ok |=> state_r == ST_IDLE && $stable(ptr_r);
  endproperty
  a_ctrl_bad: assert property (p_ctrl_bad) else $error("reserved pointer accepted");
  property p_fixed;
    @(posedge link_clk) disable iff (!link_rst_n)
      wdata_done && !pointer_increment_flag_r && !increment_range_bit_hi_r && !increment_range_bit_lo_r
      |=> $stable(ptr_r);
  endproperty
  a_fixed: assert property (p_fixed) else $error("pointer moved");
  property p_wrap_all;
    @(posedge link_clk) disable iff (!link_rst_n)
      wdata_done && pointer_increment_flag_r && (ptr_r == PTR_LAST) |=> ptr_r == PTR_FIRST;
  endproperty
  a_wrap_all: assert property (p_wrap_all) else $error("no wrap at top");
  property p_wrap_bright;
    @(posedge link_clk) disable iff (!link_rst_n)
      wdata_done && pointer_increment_flag_r && !increment_range_bit_hi_r && increment_range_bit_lo_r
      && (ptr_r == PTR_BRIGHT_LAST) |=> ptr_r == PTR_BRIGHT_FIRST;
  endproperty
  a_wrap_bright: assert property (p_wrap_bright) else $error("brightness wrap wrong");
  property p_wrap_chase;
    @(posedge link_clk) disable iff (!link_rst_n)
      wdata_done && pointer_increment_flag_r && increment_range_bit_hi_r && (ptr_r == PTR_CHASE)
      |=> ptr_r == (increment_range_bit_lo_r ? PTR_BRIGHT_FIRST : PTR_GLOBAL_FIRST);
  endproperty
  a_wrap_chase: assert property (p_wrap_chase) else $error("chase wrap wrong");
  property p_flag_kept;
    @(posedge link_clk) disable iff (!link_rst_n) wdata_done |=> $stable(pointer_increment_flag_r);
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag changed");
endmodule

// File: verilog/iamp_pkg.sv
// Purpose: shared constants of the address match and pointer block
// Assumes: six-bit register pointer, seven-bit bus addresses
// Notes: pointer values are register numbers of the device map
package iamp_pkg;
  // register numbers the pointer walks through
  localparam logic [5:0] PTR_FIRST = 6'h00;
  localparam logic [5:0] PTR_MODE = PTR_FIRST;
  localparam logic [5:0] PTR_BRIGHT_FIRST = 6'h02;
  localparam logic [5:0] PTR_BRIGHT_LAST = 6'h19;
  localparam logic [5:0] PTR_GLOBAL_FIRST = 6'h1A;
  localparam logic [5:0] PTR_CHASE = 6'h1C;
  localparam logic [5:0] PTR_SUB_ONE = 6'h23;
  localparam logic [5:0] PTR_SUB_TWO = 6'h24;
  localparam logic [5:0] PTR_SUB_THREE = 6'h25;
  localparam logic [5:0] PTR_GROUP = 6'h26;
  localparam logic [5:0] PTR_LAST = PTR_GROUP;
  // address values after reset, and the fixed soft reset call byte
  localparam logic [6:0] GROUP_ADDR_RST = 7'h70;
  localparam logic [6:0] SUB_ONE_RST = 7'h71;
  localparam logic [6:0] SUB_TWO_RST = 7'h72;
  localparam logic [6:0] SUB_THREE_RST = 7'h74;
  localparam logic [7:0] SOFT_RESET_BYTE = 8'h06;
  // enable, range and increment flag bits after reset
  localparam logic GROUP_EN_RST = 1'b1;
  localparam logic SUB_EN_RST = 1'b0;
  localparam logic RANGE_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  // field positions in the primary mode register
  localparam int MODE_RANGE_HI = 6;
  localparam int MODE_RANGE_LO = 5;
  localparam int MODE_SUB_ONE = 3;
  localparam int MODE_SUB_TWO = 2;
  localparam int MODE_SUB_THREE = 1;
  localparam int MODE_GROUP = 0;
  // field positions in the control byte
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_PTR_MSB = 5;
  // serial byte handling
  localparam logic [2:0] BIT_LAST = 3'h7;
  // events handed from the link to the core clock
  localparam int EV_W = 16;
  localparam logic [1:0] EV_WRITE = 2'h1;
  localparam logic [1:0] EV_READ = 2'h2;
  localparam logic [1:0] EV_SOFT = 2'h3;
endpackage

// File: verilog/iamp_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels that stay put for several clocks
// Notes: bits are synchronised independently
`timescale 1ns/1ps
module iamp_sync #(
  parameter int W = 1
) (
  input logic clk,
  input logic rst_n,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// File: verilog/iamp_xfer.sv
// Purpose: word crossing by toggle request and toggle acknowledge
// Assumes: source waits for busy low before a new word
// Notes: hold register stays stable while the request is in flight
`timescale 1ns/1ps
module iamp_xfer #(
  parameter int W = 8
) (
  input logic src_clk,
  input logic src_rst_n,
  input logic src_valid,
  input logic [W-1:0] src_data,
  output logic src_busy,
  input logic dst_clk,
  input logic dst_rst_n,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);
  logic req_r;
  logic [W-1:0] hold_r;
  logic req_s;
  logic seen_r;
  logic ack_s;
  logic dst_valid_r;
  logic [W-1:0] dst_data_r;

  // source side: latch word, flip request
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      req_r <= 1'b0;
      hold_r <= '0;
    end else if (src_valid && !src_busy) begin
      req_r <= ~req_r;
      hold_r <= src_data;
    end
  end

  iamp_sync #(.W(1)) u_req (.clk(dst_clk), .rst_n(dst_rst_n), .d(req_r), .q(req_s));
  iamp_sync #(.W(1)) u_ack (.clk(src_clk), .rst_n(src_rst_n), .d(seen_r), .q(ack_s));

  // destination side: a changed request means a new stable word
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      seen_r <= 1'b0;
      dst_valid_r <= 1'b0;
      dst_data_r <= '0;
    end else begin
      seen_r <= req_s;
      dst_valid_r <= req_s ^ seen_r;
      if (req_s ^ seen_r) begin
        dst_data_r <= hold_r;
      end
    end
  end

  assign src_busy = req_r ^ ack_s;
  assign dst_valid = dst_valid_r;
  assign dst_data = dst_data_r;
endmodule

// File: tb/iamp_master.sv
// Purpose: serial bus master model on the far side of the link
// Assumes: sda is resolved outside with a pull-up
// Notes: Q mclk cycles per quarter bit, scl high lasts 2*Q
`timescale 1ns/1ps
module iamp_master #(
  parameter int Q = 25
) (
  input wire logic mclk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sdm = 1'b1
);
  ////////////////////////////////////////////////////////////////////////
  // one quarter bit step, pins change only on the falling edge
  task automatic set(input logic c, input logic d);
    scl = c;
    sdm = d;
    repeat (Q) @(negedge mclk);
  endtask
  // sda falls under a high scl
  task automatic start();
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    set(1'b1, 1'b0);
    set(1'b0, 1'b0);
  endtask
  task automatic stop();
    set(1'b0, 1'b0);
    set(1'b1, 1'b0);
    set(1'b1, 1'b1);
  endtask
  // data settles while scl is low, sampled mid high phase
  task automatic bit1(input logic d, output logic s);
    set(1'b0, d);
    set(1'b1, d);
    s = sda;
    set(1'b1, d);
    set(1'b0, d);
  endtask
  // msb first, then the ninth bit released for the ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit1(b[i], s);
    bit1(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit1(1'b1, s);
      b[i] = s;
    end
    bit1(nak, s);
  endtask
endmodule

// File: tb/tb_iamp_top.sv
// Purpose: bench for address match and register pointer
// Assumes: register stand-in returns 2'b10 and the register number
// Notes: straps drawn among reserved addresses on purpose
`timescale 1ns/1ps
module tb_iamp_top import iamp_pkg::*; ;
  logic mclk = 1'b0, lclk = 1'b0, rst_n = 1'b0, scl, sdm, so, soe, wr, rd, srst;
  logic [6:0] strap = 7'h78;
  logic [5:0] ra;
  logic [7:0] wd, rdat = 8'h00;
  logic [31:0] seed = 32'hFCF3082A;
  logic [13:0] wq[$];
  int n_mismatch = 0, samples_checked = 0, n_soft = 0;
  wire sda = sdm & (~soe | so);
  always #2 mclk = ~mclk;
  initial begin
    #1.7;
    forever #6 lclk = ~lclk;
  end
  iamp_master i_master (.mclk(mclk), .sda(sda), .scl(scl), .sdm(sdm));
  iamp_top i_dut (.mclk(mclk), .rst_n(rst_n), .link_clk(lclk), .scl_i(scl), .sda_i(sda), .sda_o(so),
    .sda_oe(soe), .strap_pin(strap), .reg_wr(wr), .reg_rd(rd), .reg_addr(ra), .reg_wdata(wd),
    .reg_rdata(rdat), .soft_reset_call(srst));
  ////////////////////////////////////////////////////////////////////////
  // register stand-in, log of writes and soft call pulses
  always @(negedge mclk) begin
    if (rd === 1'b1) rdat <= {2'h2, ra};
    if (wr === 1'b1) wq.push_back({ra, wd});
    if (srst === 1'b1) n_soft++;
  end
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %0h %0h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // expected pointer after one data byte
  function automatic logic [5:0] nxt(input logic [5:0] p, input logic f, input logic [1:0] m);
    if (!f) return p;
    if (p == PTR_LAST) return PTR_FIRST;
    if (m == 2'h1 && p == PTR_BRIGHT_LAST) return PTR_BRIGHT_FIRST;
    if (m[1] && p == PTR_CHASE) return m[0] ? PTR_BRIGHT_FIRST : PTR_GLOBAL_FIRST;
    return p + 6'h01;
  endfunction
  // keeps mode and group address intact when a wrap lands on them
  function automatic logic [7:0] sdat(input logic [5:0] p, input logic [1:0] m, input logic [7:0] r);
    if (p == PTR_MODE) return {1'b0, m, 5'h01};
    if (p == PTR_GROUP) return {GROUP_ADDR_RST, 1'b0};
    return r;
  endfunction
  task automatic adr(input logic [7:0] b, input logic e);
    logic a;
    i_master.start();
    i_master.wbyte(b, a);
    chk({15'h0, e}, {15'h0, a});
  endtask
  task automatic wrt(input logic [7:0] c, input logic [1:0] m, input int n);
    logic a;
    logic [5:0] p;
    logic [7:0] d;
    p = c[5:0];
    adr({strap, 1'b0}, 1'b1);
    i_master.wbyte(c, a);
    chk(16'h1, {15'h0, a});
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      d = sdat(p, m, seed[7:0]);
      i_master.wbyte(d, a);
      chk({2'h0, p, d}, {2'h0, wq.pop_front()});
      p = nxt(p, c[7], m);
    end
    i_master.stop();
  endtask
  // one register write with a fixed pointer
  task automatic cfg(input logic [5:0] p, input logic [7:0] d);
    logic a;
    adr({strap, 1'b0}, 1'b1);
    i_master.wbyte({2'h0, p}, a);
    i_master.wbyte(d, a);
    chk({2'h0, p, d}, {2'h0, wq.pop_front()});
    i_master.stop();
  endtask
  initial begin
    logic a;
    logic [7:0] b;
    logic [5:0] p;
    logic [9:0] rows[5];
    logic [8:0] at[8];
    logic [8:0] cf[4];
    rows = '{10'h005, 10'h0A6, 10'h199, 10'h29C, 10'h39C};
    seed = xs(seed);
    strap = 7'h78 | {4'h0, seed[2:0]};
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (20) @(negedge mclk);
    foreach (rows[i]) begin
      wrt(8'h00, rows[i][9:8], 1);
      wrt(rows[i][7:0], rows[i][9:8], 3);
    end
    wrt(8'h00, 2'h0, 1);
    wrt(8'h8A, 2'h0, 0);
    adr({strap, 1'b1}, 1'b1);
    p = 6'h0A;
    for (int i = 0; i < 2; i++) begin
      i_master.rbyte(i == 1, b);
      chk({10'h2, p}, {8'h0, b});
      p = nxt(p, 1'b1, 2'h0);
    end
    i_master.stop();
    adr({strap, 1'b0}, 1'b1);
    i_master.wbyte(8'hA7, a);
    chk(16'h0, {15'h0, a});
    i_master.stop();
    chk(16'h0, 16'(wq.size()));
    at = '{9'h1E0, 9'h1E1, 9'h0E2, 9'h0E4, 9'h0E8, 9'h007, {1'b0, strap ^ 7'h10, 1'b0}, 9'h106};
    foreach (at[i]) begin
      adr(at[i][7:0], at[i][8]);
      if (at[i][8] & at[i][0]) i_master.rbyte(1'b1, b);
      i_master.stop();
    end
    // enable the first sub-call matcher, then move it and the group-call address
    cfg(PTR_MODE, 8'h09);
    cfg(PTR_SUB_ONE, 8'h6A);
    cfg(PTR_GROUP, 8'h56);
    cf = '{9'h0E2, 9'h16A, 9'h156, 9'h0E0};
    foreach (cf[i]) begin
      adr(cf[i][7:0], cf[i][8]);
      i_master.stop();
    end
    repeat (20) @(negedge mclk);
    chk(16'h1, 16'(n_soft));
    complete_run();
  end
  // hang guard
  initial begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end
endmodule
